// [dv/hb_fault_sva.sv]
`timescale 1ns/10ps
`include "hb_fault_params.svh"

module hb_fault_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link and sleep
  input wire logic csN,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic sleepInputN,
  // Power stage and status
  input wire hb_fault_pkg::fault_in_t faultIn,
  input wire logic [`NUM_SW-1:0] switchOn,
  input wire logic outputsTriState,
  input wire logic [`WORD_BITS-1:0] statusWord,
  input wire hb_fault_pkg::flags_t flags
);
  import hb_fault_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Saturating run length of the raw undervoltage input
  logic [9:0] uvCnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) uvCnt_r <= 10'h000;
    else if (!faultIn.uvRaw) uvCnt_r <= 10'h000;
    else if (uvCnt_r != 10'h3ff) uvCnt_r <= uvCnt_r + 10'h001;
  end

  a_unused_bits_zero: assert property (statusWord[12:7] == 6'h00)
    else $error("unused status bits set");
  a_uv_filter_held: assert property ($rose(flags.supplyFail) |-> uvCnt_r > 10'(`UV_FILTER_CYC))
    else $error("supply flag set before filter delay");
  a_sleep_all_off: assert property (!sleepInputN [*6] |-> switchOn == 6'h00 && outputsTriState && statusWord == 16'h0000)
    else $error("sleep did not clear outputs");
  a_wake_drives: assert property (sleepInputN [*8] |-> !outputsTriState)
    else $error("outputs still tri-stated after wake");
  a_thermal_off: assert property (faultIn.shutdownOver [*7] |-> switchOn == 6'h00)
    else $error("switch on during thermal shutdown");
  a_prewarn_first: assert property ($rose(serialOutEn) |-> serialOut == flags.tempPrewarning)
    else $error("first serial bit not prewarning");
  a_idle_released: assert property (csN [*5] |-> !serialOutEn)
    else $error("serial out driven while deselected");
  a_sticky_clear: assert property (($fell(flags.supplyFail) || $fell(flags.openLoad) || $fell(flags.shortDetected)) |-> csN)
    else $error("sticky flag cleared inside a frame");

  c_supply_fail: cover property ($rose(flags.supplyFail));
  c_frame_end: cover property ($fell(serialOutEn));
  c_sleep: cover property ($rose(outputsTriState));
endmodule : hb_fault_sva

bind half_bridge_fault_supervisor hb_fault_sva chk (.clk(clk), .rst(rst), .csN(csN), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .sleepInputN(sleepInputN), .faultIn(faultIn), .switchOn(switchOn),
  .outputsTriState(outputsTriState), .statusWord(statusWord), .flags(flags));

// [dv/hb_host_model.sv]
`timescale 1ns/10ps

module hb_host_model (
  // System clock for pacing
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic csN,
  output logic serialIn,
  input wire logic serialOut
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    serialIn = 1'b0;
  end

  // Half period of 7 cycles keeps the link under 2 MHz
  task automatic xfer(input logic [15:0] din, input int nBits, output logic [15:0] dout);
    dout = 16'h0000;
    @(negedge clk) csN = 1'b0;
    repeat (8) @(negedge clk);
    for (int k = 0; k < nBits; k++) begin
      serialIn = din[k];
      repeat (7) @(negedge clk);
      sclk = 1'b1;
      dout[k] = serialOut;
      repeat (7) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    csN = 1'b1;
    serialIn = ~serialIn;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : hb_host_model

// [dv/testbench.sv]
`timescale 1ns/10ps
`include "hb_fault_params.svh"

module testbench;
  import hb_fault_pkg::*;
  logic clk = 1'b0;
  logic rst;
  logic sleepInputN;
  logic sclk, csN, serialIn, serialOut, serialOutEn, outputsTriState;
  fault_in_t faults;
  logic [`NUM_SW-1:0] switchOn;
  logic [`WORD_BITS-1:0] statusWord;
  flags_t flags;
  logic [15:0] rd;
  int fail_count = 0;
  int tests_run = 0;

  always #20 clk = ~clk;

  half_bridge_fault_supervisor DUT (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .sleepInputN(sleepInputN), .faultIn(faults),
    .switchOn(switchOn), .outputsTriState(outputsTriState), .statusWord(statusWord), .flags(flags));
  // Released data line floats to the inverse of its last bit
  wire soLine = serialOutEn ? serialOut : ~serialOut;
  hb_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .serialIn(serialIn), .serialOut(soLine));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  task automatic sw(input logic [5:0] e);
    chk("switchOn", 16'(switchOn), 16'(e));
  endtask : sw

  function automatic logic [15:0] w(input logic [5:0] s, input logic overcurrent_shutdown_enable, input logic clr);
    return {2'b00, overcurrent_shutdown_enable, 6'h00, s, clr};
  endfunction : w

  task automatic send(input logic [15:0] d, input int n);
    host.xfer(d, n, rd);
    wt(6);
  endtask : send

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    sleepInputN = 1'b1;
    faults = '0;
    faults.prewarnBelow = 1'b1;
    faults.switchOnBelow = 1'b1;
    wt(3);
    rst = 1'b0;
    wt(8);
    send(w(6'h00, 1'b1, 1'b0), 16);
    chk("status", rd, 16'h0000);
    chk("tri", 16'(outputsTriState), 16'h0000);
    send(w(6'h3f, 1'b1, 1'b0), 16);
    sw(6'h3f);
    send(w(6'h3f, 1'b1, 1'b0), 16);
    chk("status", rd, 16'h007e);
    $display("Test switching done");
    faults.prewarnBelow = 1'b0;
    faults.prewarnOver = 1'b1;
    wt(10);
    chk("prewarn", 16'(flags.tempPrewarning), 16'h0001);
    send(w(6'h00, 1'b1, 1'b0), 1);
    chk("prewarnOut", 16'(rd[0]), 16'h0001);
    sw(6'h3f);
    faults.prewarnOver = 1'b0;
    faults.prewarnBelow = 1'b1;
    wt(10);
    chk("prewarn", 16'(flags.tempPrewarning), 16'h0000);
    $display("Test prewarning done");
    faults.uvRaw = 1'b1;
    wt(200);
    faults.uvRaw = 1'b0;
    wt(10);
    chk("supply", 16'(flags.supplyFail), 16'h0000);
    faults.uvRaw = 1'b1;
    wt(300);
    chk("supply", 16'(flags.supplyFail), 16'h0001);
    sw(6'h00);
    faults.uvRaw = 1'b0;
    wt(10);
    sw(6'h3f);
    chk("supply", 16'(flags.supplyFail), 16'h0001);
    send(w(6'h3f, 1'b1, 1'b1), 16);
    chk("supply", 16'(flags.supplyFail), 16'h0000);
    $display("Test supply done");
    faults.openLoad = 6'h01;
    wt(300);
    chk("open", 16'(flags.openLoad), 16'h0001);
    faults.openLoad = 6'h00;
    wt(10);
    chk("open", 16'(flags.openLoad), 16'h0001);
    send(w(6'h3f, 1'b1, 1'b1), 16);
    chk("open", 16'(flags.openLoad), 16'h0000);
    chk("statusWord", statusWord, 16'h007e);
    $display("Test open load done");
    faults.overCurrent = 6'h04;
    wt(300);
    sw(6'h3b);
    chk("short", 16'(flags.shortDetected), 16'h0001);
    faults.overCurrent = 6'h00;
    send(w(6'h3f, 1'b1, 1'b1), 16);
    sw(6'h3f);
    chk("short", 16'(flags.shortDetected), 16'h0000);
    send(w(6'h3f, 1'b0, 1'b0), 16);
    faults.overCurrent = 6'h04;
    wt(300);
    sw(6'h3f);
    chk("short", 16'(flags.shortDetected), 16'h0001);
    faults.overCurrent = 6'h00;
    send(w(6'h3f, 1'b1, 1'b1), 16);
    chk("short", 16'(flags.shortDetected), 16'h0000);
    $display("Test overcurrent done");
    faults.switchOnBelow = 1'b0;
    faults.shutdownOver = 1'b1;
    wt(10);
    sw(6'h00);
    faults.shutdownOver = 1'b0;
    send(w(6'h3f, 1'b1, 1'b1), 16);
    sw(6'h00);
    faults.switchOnBelow = 1'b1;
    wt(10);
    send(w(6'h3f, 1'b1, 1'b1), 16);
    sw(6'h3f);
    $display("Test thermal done");
    sleepInputN = 1'b0;
    wt(10);
    sw(6'h00);
    chk("tri", 16'(outputsTriState), 16'h0001);
    chk("statusWord", statusWord, 16'h0000);
    sleepInputN = 1'b1;
    wt(10);
    chk("tri", 16'(outputsTriState), 16'h0000);
    sw(6'h00);
    send(w(6'h3f, 1'b1, 1'b0), 16);
    sw(6'h3f);
    $display("Test sleep done");
    stop_test();
  end
endmodule : testbench

// [logic/half_bridge_fault_supervisor.sv]
`timescale 1ns/10ps
`include "hb_fault_params.svh"

// Functional notes
// [RQ1] Recognised undervoltage sets supply flag, switches off
// [RQ2] Undervoltage counts only after filter delay
// [RQ3] Outputs return at once when supply recovers
// [RQ4] Supply flag sticky until status clear
// [RQ5] Open-load flag on low current in on switch
// [RQ6] Open-load filtered; flag sticky until clear
// [RQ7] Prewarning sets above, clears below reset
// [RQ8] Prewarning driven out at chip select fall
// [RQ9] Early chip select rise abandons transfer unchanged
// [RQ10] Thermal shutdown disables all, status bits low
// [RQ11] Restart needs cool switch-on level and clear
// [RQ12] Overcurrent shutdown after filter when enabled
// [RQ13] Overcurrent shutoff sets short flag, status low
// [RQ14] Shutdown disabled: flag only, outputs untouched
// [RQ15] Status clear resets short, re-enables outputs
// [RQ16] Sleep low: switches off, tri-stated, status cleared
// [RQ17] Sleep release acts as internal power-on reset
// [RQ18] Host serial clock at most 2 MHz
// [RQ19] Status word bit layout
// [RQ20] Input word bit layout
// [RQ21] Input word reset: shutdown enable high, rest low
// [RQ22] Switch status bits follow real state, not cleared
// [RQ23] Status clear is one event per accepted word
// [RQ24] Filters count clock cycles, restart on release

module half_bridge_fault_supervisor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // Sleep pin
  input wire logic sleepInputN,
  // Comparator results from the power stage
  input wire hb_fault_pkg::fault_in_t faultIn,
  // Switch drive
  output logic [`NUM_SW-1:0] switchOn,
  output logic outputsTriState,
  // Status
  output logic [`WORD_BITS-1:0] statusWord,
  output hb_fault_pkg::flags_t flags
);
  import hb_fault_pkg::*;

  localparam int FAULT_W = $bits(fault_in_t);
  localparam int SYNC_W = FAULT_W + 4;

  // Filter counter step: hold at the limit, restart when the condition drops
  function automatic logic [`FILT_W-1:0] filtNext(
    input logic [`FILT_W-1:0] cnt,
    input logic cond,
    input logic [`FILT_W-1:0] limit
  );
    logic [`FILT_W-1:0] res;
    res = '0;
    if (cond) begin
      res = (cnt == limit) ? cnt : cnt + `FILT_W'(1);
    end
    return res;
  endfunction : filtNext

  localparam logic [`FILT_W-1:0] UV_LIMIT = `FILT_W'(`UV_FILTER_CYC);
  localparam logic [`FILT_W-1:0] FAULT_LIMIT = `FILT_W'(`FAULT_FILTER_CYC);

  // Two-flop synchronisers for every pin and comparator input
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  wire [SYNC_W-1:0] rawVec = {faultIn, sleepInputN, sclk, csN, serialIn};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= rawVec;
      sync2_r <= sync1_r;
    end
  end

  fault_in_t fs;
  wire serialInS = sync2_r[0];
  wire csNS = sync2_r[1];
  wire sclkS = sync2_r[2];
  wire sleepNS = sync2_r[3];
  assign fs = fault_in_t'(sync2_r[SYNC_W-1:4]);

  // Sleep held low keeps everything in reset; release is a fresh start
  wire sleepActive = ~sleepNS; // see [RQ16] see [RQ17]

  logic csPrev_r;
  logic sclkPrev_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csPrev_r <= 1'b1;
      sclkPrev_r <= 1'b0;
    end else begin
      csPrev_r <= csNS;
      sclkPrev_r <= sclkS;
    end
  end

  wire csFall = csPrev_r & ~csNS;
  wire csRise = ~csPrev_r & csNS;
  wire sclkRise = ~sclkPrev_r & sclkS;
  wire sclkFall = sclkPrev_r & ~sclkS;

  // Input word and one-shot clear
  logic [`NUM_SW-1:0] cmd_r;
  logic ocsEn_r;
  logic clrEvt_r;
  logic [`WORD_BITS-1:0] shift_r;
  logic [4:0] bitCnt_r;
  link_state_t linkState_r;

  wire fullWord = (bitCnt_r == 5'(`WORD_BITS));
  wire acceptWord = (linkState_r == LINK_XFER) & csRise & fullWord; // see [RQ9]
  localparam logic [`WORD_BITS-1:0] IW_RST = `IW_RESET;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= IW_RST[`IW_CMD_LSB +: `NUM_SW];
      ocsEn_r <= IW_RST[`IW_OCS_BIT];
      clrEvt_r <= 1'b0;
    end else if (sleepActive) begin
      cmd_r <= IW_RST[`IW_CMD_LSB +: `NUM_SW]; // see [RQ21]
      ocsEn_r <= IW_RST[`IW_OCS_BIT];
      clrEvt_r <= 1'b0;
    end else begin
      clrEvt_r <= acceptWord & shift_r[`IW_CLEAR_BIT]; // see [RQ23]
      if (acceptWord) begin
        cmd_r <= shift_r[`IW_CMD_LSB +: `NUM_SW]; // see [RQ20]
        ocsEn_r <= shift_r[`IW_OCS_BIT];
      end
    end
  end

  // Undervoltage
  logic [`FILT_W-1:0] uvCnt_r;
  logic uvActive_r;
  logic supplyFail_r;
  wire uvFilt = fs.uvRaw & (uvCnt_r == UV_LIMIT); // see [RQ2]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uvCnt_r <= '0;
      uvActive_r <= 1'b0;
      supplyFail_r <= 1'b0;
    end else if (sleepActive) begin
      uvCnt_r <= '0;
      uvActive_r <= 1'b0;
      supplyFail_r <= 1'b0;
    end else begin
      uvCnt_r <= filtNext(uvCnt_r, fs.uvRaw, UV_LIMIT); // see [RQ24]
      uvActive_r <= uvFilt | (uvActive_r & fs.uvRaw); // see [RQ1] see [RQ3]
      supplyFail_r <= uvFilt | (supplyFail_r & ~clrEvt_r); // see [RQ4]
    end
  end

  // Temperature
  logic prewarn_r;
  logic thermShut_r;
  wire thermRelease = clrEvt_r & fs.switchOnBelow & ~fs.shutdownOver;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prewarn_r <= 1'b0;
      thermShut_r <= 1'b0;
    end else if (sleepActive) begin
      prewarn_r <= 1'b0;
      thermShut_r <= 1'b0;
    end else begin
      prewarn_r <= fs.prewarnOver | (prewarn_r & ~fs.prewarnBelow); // see [RQ7]
      thermShut_r <= fs.shutdownOver | (thermShut_r & ~thermRelease); // see [RQ10] see [RQ11]
    end
  end

  // Per-switch open-load and overcurrent filters
  logic [`NUM_SW-1:0] switchOn_r;
  logic [`NUM_SW-1:0] ocOff_r;
  logic [`NUM_SW-1:0] olFilt;
  logic [`NUM_SW-1:0] ocFilt;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SW; gi++) begin : g_sw
      logic [`FILT_W-1:0] olCnt_r;
      logic [`FILT_W-1:0] ocCnt_r;
      wire olCond = fs.openLoad[gi] & switchOn_r[gi]; // see [RQ5]
      wire ocCond = fs.overCurrent[gi] & switchOn_r[gi];
      assign olFilt[gi] = olCond & (olCnt_r == FAULT_LIMIT); // see [RQ6]
      assign ocFilt[gi] = ocCond & (ocCnt_r == FAULT_LIMIT); // see [RQ12]

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          olCnt_r <= '0;
          ocCnt_r <= '0;
          ocOff_r[gi] <= 1'b0;
        end else if (sleepActive) begin
          olCnt_r <= '0;
          ocCnt_r <= '0;
          ocOff_r[gi] <= 1'b0;
        end else begin
          olCnt_r <= filtNext(olCnt_r, olCond, FAULT_LIMIT); // see [RQ24]
          ocCnt_r <= filtNext(ocCnt_r, ocCond, FAULT_LIMIT); // see [RQ24]
          // A new trip in the clear cycle keeps the switch off
          ocOff_r[gi] <= (ocFilt[gi] & ocsEn_r) | (ocOff_r[gi] & ~clrEvt_r); // see [RQ14] see [RQ15]
        end
      end
    end
  endgenerate

  logic openLoad_r;
  logic shortDet_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      openLoad_r <= 1'b0;
      shortDet_r <= 1'b0;
    end else if (sleepActive) begin
      openLoad_r <= 1'b0;
      shortDet_r <= 1'b0;
    end else begin
      openLoad_r <= (|olFilt) | (openLoad_r & ~clrEvt_r); // see [RQ6]
      shortDet_r <= (|ocFilt) | (shortDet_r & ~clrEvt_r); // see [RQ13] see [RQ14]
    end
  end

  // Switch drive: one flop after the fault state, so status equals drive
  wire globalOff = uvActive_r | thermShut_r; // see [RQ1] see [RQ10]
  wire [`NUM_SW-1:0] switchNxt = cmd_r & ~ocOff_r & {`NUM_SW{~globalOff}}; // see [RQ13]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switchOn_r <= '0;
    end else if (sleepActive) begin
      switchOn_r <= '0; // see [RQ16]
    end else begin
      switchOn_r <= switchNxt;
    end
  end

  wire [`WORD_BITS-1:0] statusNxt = {supplyFail_r, openLoad_r, shortDet_r,
                                     6'h00, switchOn_r, prewarn_r}; // see [RQ19] see [RQ22]

  // Serial link: one register shifts status out and the input word in
  logic serialOut_r;
  logic serialOutEn_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkState_r <= LINK_IDLE;
      shift_r <= '0;
      bitCnt_r <= '0;
      serialOut_r <= 1'b0;
      serialOutEn_r <= 1'b0;
    end else if (sleepActive) begin
      linkState_r <= LINK_IDLE;
      shift_r <= '0;
      bitCnt_r <= '0;
      serialOut_r <= 1'b0;
      serialOutEn_r <= 1'b0;
    end else begin
      case (linkState_r)
        LINK_IDLE: begin
          if (csFall) begin
            shift_r <= statusNxt;
            bitCnt_r <= '0;
            serialOut_r <= statusNxt[`SW_PREWARN_BIT]; // see [RQ8]
            serialOutEn_r <= 1'b1;
            linkState_r <= LINK_XFER;
          end
        end
        LINK_XFER: begin
          if (csRise) begin
            serialOutEn_r <= 1'b0; // see [RQ9]
            linkState_r <= LINK_IDLE;
          end else if (sclkRise) begin
            shift_r <= {serialInS, shift_r[`WORD_BITS-1:1]};
            // Saturating count: longer frames are refused, not wrapped
            if (bitCnt_r != 5'h1f) begin
              bitCnt_r <= bitCnt_r + 5'h01;
            end
          end else if (sclkFall) begin
            serialOut_r <= shift_r[0];
          end
        end
        default: begin
          linkState_r <= LINK_IDLE;
          serialOutEn_r <= 1'b0;
        end
      endcase
    end
  end

  // Registered copies for the outputs
  logic [`WORD_BITS-1:0] statusWord_r;
  flags_t flags_r;
  logic triState_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusWord_r <= '0;
      flags_r <= '0;
      triState_r <= 1'b1;
    end else begin
      statusWord_r <= statusNxt;
      flags_r <= '{supplyFail: supplyFail_r, openLoad: openLoad_r,
                   shortDetected: shortDet_r, tempPrewarning: prewarn_r};
      triState_r <= sleepActive; // see [RQ16]
    end
  end

  assign switchOn = switchOn_r;
  assign outputsTriState = triState_r;
  assign serialOut = serialOut_r;
  assign serialOutEn = serialOutEn_r;
  assign statusWord = statusWord_r;
  assign flags = flags_r;

endmodule : half_bridge_fault_supervisor

// [logic/hb_fault_params.svh]
`ifndef HB_FAULT_PARAMS_SVH
`define HB_FAULT_PARAMS_SVH

`define NUM_SW 6
`define WORD_BITS 16
`define CLK_PERIOD_NS 40
`define UV_FILTER_NS 10000
`define FAULT_FILTER_NS 10000
`define UV_FILTER_CYC ((`UV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_FILTER_CYC ((`FAULT_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_W 9

`define SW_PREWARN_BIT 0
`define SW_STAT_LSB 1
`define SW_SHORT_BIT 13
`define SW_OPEN_BIT 14
`define SW_SUPPLY_BIT 15

`define IW_CLEAR_BIT 0
`define IW_CMD_LSB 1
`define IW_OCS_BIT 13
`define IW_RESET 16'h2000

`endif

// [logic/hb_fault_pkg.sv]
`include "hb_fault_params.svh"

package hb_fault_pkg;

  typedef struct packed {
    logic uvRaw;
    logic prewarnOver;
    logic prewarnBelow;
    logic shutdownOver;
    logic switchOnBelow;
    logic [`NUM_SW-1:0] openLoad;
    logic [`NUM_SW-1:0] overCurrent;
  } fault_in_t;

  typedef struct packed {
    logic supplyFail;
    logic openLoad;
    logic shortDetected;
    logic tempPrewarning;
  } flags_t;

  typedef enum logic {LINK_IDLE, LINK_XFER} link_state_t;

endpackage : hb_fault_pkg
